// file: core/dram_page_mode_address_mux.sv
`include "dram_mux_cfg.svh"

module dram_page_mode_address_mux (
	// clock, reset, enable
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic clk_en,
	// avalon-mm register slave
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// transfer requests
	input wire logic req_valid,
	output logic req_ready,
	input wire dram_mux_pkg::xfer_req_t req,
	output logic xfer_done,
	// dram pins
	output dram_mux_pkg::pin_out_t dram_pins
);
	import dram_mux_pkg::*;

	// sequencer states
	typedef enum logic [2:0] {ST_IDLE, ST_PRECHARGE, ST_ROW, ST_COL, ST_GAP} state_t;

	// software visible registers
	bank_ctrl_t bank0_ctrl_reg; // bank 0 control
	bank_ctrl_t bank1_ctrl_reg; // bank 1 control
	strobe_timing_t timing_reg; // shared timing
	logic ack_reg; // bus answer phase
	logic [31:0] readdata_reg; // captured read data

	// transfer state
	state_t state_reg; // sequencer state
	state_t state_next;
	xfer_req_t cur_reg; // transfer in flight
	xfer_req_t cur_next;
	bank_ctrl_t cur_ctrl_reg; // bank setup frozen at accept
	bank_ctrl_t cur_ctrl_next;
	logic [2:0] beats_reg; // beats still to run
	logic [2:0] beats_next;
	logic [3:0] cnt_reg; // phase cycle counter
	logic [3:0] cnt_next;
	logic after_pre_reg; // precharge then row, else idle
	logic after_pre_next;
	logic done_reg; // one cycle completion
	logic done_next;
	pin_out_t pins_reg; // registered pins
	pin_out_t pins_next;

	// byte enable merge, used for every writable register
	function automatic logic [31:0] be_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] be);
		logic [31:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				res[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		be_merge = res;
	endfunction

	// ---------------- register slave ----------------

	// address decode
	wire bus_req = avs_read | avs_write;
	wire sel_b0 = avs_address == `REG_BANK0_CTRL;
	wire sel_b1 = avs_address == `REG_BANK1_CTRL;
	wire sel_tim = avs_address == `REG_STROBE_TIMING;
	wire sel_stat = avs_address == `REG_STATUS;
	// writes land only on the cycle waitrequest is low
	wire bus_commit = clk_en & ack_reg & avs_write;

	// status word shows the sequencer's own state
	wire busy = state_reg != ST_IDLE;
	wire [1:0] open_valid;
	wire [31:0] status_word = (32'(busy) << `STAT_BUSY_BIT) |
		(32'(open_valid) << `STAT_OPEN_LSB) | (32'(beats_reg) << `STAT_BEATS_LSB);

	// read selection, unmapped offsets read zero
	wire [31:0] rd_mux = sel_b0 ? {25'h0, bank0_ctrl_reg} :
		sel_b1 ? {25'h0, bank1_ctrl_reg} :
		sel_tim ? {20'h0, timing_reg} :
		sel_stat ? status_word : 32'h0;

	// every access is answered on its second enabled cycle, so a frozen cycle loses no write
	assign avs_waitrequest = bus_req & ~(ack_reg & clk_en);
	assign avs_readdata = readdata_reg;

	// answer phase toggle
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			ack_reg <= 1'h0;
		end else if (clk_en) begin
			ack_reg <= bus_req & ~ack_reg;
		end
	end

	// read data captured one cycle before it is sampled
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			readdata_reg <= 32'h0;
		end else if (clk_en & avs_read & ~ack_reg) begin
			readdata_reg <= rd_mux;
		end
	end

	// writable registers; unmapped writes are dropped
	wire [31:0] b0_wr = be_merge({25'h0, bank0_ctrl_reg}, avs_writedata, avs_byteenable);
	wire [31:0] b1_wr = be_merge({25'h0, bank1_ctrl_reg}, avs_writedata, avs_byteenable);
	wire [31:0] tim_wr = be_merge({20'h0, timing_reg}, avs_writedata, avs_byteenable);

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			bank0_ctrl_reg <= `BANK_CTRL_RESET;
			bank1_ctrl_reg <= `BANK_CTRL_RESET;
			timing_reg <= `STROBE_TIMING_RESET;
		end else if (bus_commit) begin
			if (sel_b0) begin
				bank0_ctrl_reg <= b0_wr[6:0];
			end
			if (sel_b1) begin
				bank1_ctrl_reg <= b1_wr[6:0];
			end
			if (sel_tim) begin
				timing_reg <= tim_wr[11:0];
			end
		end
	end

	// ---------------- transfer decode ----------------

	// setup of the bank that a new request targets
	wire accept = req_valid & req_ready;
	wire bank_ctrl_t new_ctrl = req.bank ? bank1_ctrl_reg : bank0_ctrl_reg;
	wire [1:0] new_shift = port_shift(new_ctrl.port_width);
	wire new_burst = req.size > new_shift;
	wire new_fast = (new_ctrl.page_mode == `MODE_FAST) |
		((new_ctrl.page_mode == `MODE_BURST) & new_burst);
	wire [2:0] new_beats = new_burst ? 3'(3'h1 << (req.size - new_shift)) : 3'h1;

	// same decode for the transfer in flight
	wire [1:0] cur_shift = port_shift(cur_ctrl_reg.port_width);
	wire cur_burst = cur_reg.size > cur_shift;
	wire cur_fast = (cur_ctrl_reg.page_mode == `MODE_FAST) |
		((cur_ctrl_reg.page_mode == `MODE_BURST) & cur_burst);
	wire keep_open = cur_ctrl_reg.page_mode == `MODE_FAST;
	wire [27:0] beat_step = 28'h1 << cur_shift;

	// page lookup addresses follow the request while idle
	wire idle = state_reg == ST_IDLE;
	wire [27:0] chk_addr = idle ? req.addr : cur_reg.addr;
	wire chk_bank = idle ? req.bank : cur_reg.bank;
	wire [1:0] chk_page = idle ? new_ctrl.page_size : cur_ctrl_reg.page_size;
	wire page_hit;
	wire open_pulse = clk_en & (state_reg == ST_ROW);
	wire close_pulse = clk_en & (state_reg == ST_PRECHARGE);

	// open page bookkeeping
	page_tracker u_tracker (
		.clk_sys(clk_sys),
		.reset(reset),
		.clk_en(clk_en),
		.chk_addr(chk_addr),
		.chk_bank(chk_bank),
		.chk_page_size(chk_page),
		.open_pulse(open_pulse),
		.close_pulse(close_pulse),
		.hit(page_hit),
		.open_valid(open_valid)
	);

	wire mux_on = ~cur_reg.ext | cur_ctrl_reg.ext_mux;
	wire [27:0] col_addr;

	col_addr_mux u_col (
		.internal_transfer_address(cur_reg.addr),
		.bank_port_width(cur_ctrl_reg.port_width),
		.bank_page_size(cur_ctrl_reg.page_size),
		.mux_on(mux_on),
		.col_addr(col_addr)
	);

	// byte lane strobes; narrow ports sit on the low lanes
	wire [3:0] lanes = (cur_shift == 2'h0) ? 4'h1 :
		(cur_shift == 2'h1) ? ((cur_reg.size == 2'h0) ? (4'h1 << cur_reg.addr[0]) : 4'h3) :
		(cur_reg.size == 2'h0) ? (4'h1 << cur_reg.addr[1:0]) :
		(cur_reg.size == 2'h1) ? (cur_reg.addr[1] ? 4'hc : 4'h3) : 4'hf;

	// ---------------- sequencer ----------------

	assign req_ready = clk_en & idle;

	// next state; precharge, row and column lengths come from the one timing register, the gap is one cycle
	always_comb begin
		state_next = state_reg;
		cur_next = cur_reg;
		cur_ctrl_next = cur_ctrl_reg;
		beats_next = beats_reg;
		cnt_next = (cnt_reg == 4'h0) ? 4'h0 : cnt_reg - 4'h1;
		after_pre_next = after_pre_reg;
		done_next = 1'h0;
		case (state_reg)
			ST_IDLE: begin
				if (accept) begin
					cur_next = req;
					cur_ctrl_next = new_ctrl;
					beats_next = new_beats;
					if (new_fast & page_hit) begin
						state_next = ST_COL;
						cnt_next = timing_reg.cas_width;
					end else if (open_valid != 2'h0) begin
						state_next = ST_PRECHARGE;
						after_pre_next = 1'h1;
						cnt_next = timing_reg.precharge;
					end else begin
						state_next = ST_ROW;
						cnt_next = timing_reg.ras_to_cas;
					end
				end
			end
			ST_PRECHARGE: begin
				// all row strobes negated while this runs
				if (cnt_reg == 4'h0) begin
					state_next = after_pre_reg ? ST_ROW : ST_IDLE;
					cnt_next = timing_reg.ras_to_cas;
				end
			end
			ST_ROW: begin
				if (cnt_reg == 4'h0) begin
					state_next = ST_COL;
					cnt_next = timing_reg.cas_width;
				end
			end
			ST_COL: begin
				if (cnt_reg == 4'h0) begin
					if (beats_reg == 3'h1) begin
						done_next = 1'h1;
						beats_next = 3'h0;
						// only fast page leaves the row open after the transfer
						if (keep_open) begin
							state_next = ST_IDLE;
						end else begin
							state_next = ST_PRECHARGE;
							after_pre_next = 1'h0;
							cnt_next = timing_reg.precharge;
						end
					end else begin
						beats_next = beats_reg - 3'h1;
						cur_next.addr = cur_reg.addr + beat_step;
						if (cur_fast) begin
							state_next = ST_GAP;
						end else begin
							state_next = ST_PRECHARGE;
							after_pre_next = 1'h1;
							cnt_next = timing_reg.precharge;
						end
					end
				end
			end
			ST_GAP: begin
				// one cycle with column strobes high between beats
				if (page_hit) begin
					state_next = ST_COL;
					cnt_next = timing_reg.cas_width;
				end else begin
					state_next = ST_PRECHARGE;
					after_pre_next = 1'h1;
					cnt_next = timing_reg.precharge;
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	// pins follow the sequencer one cycle later, straight from flip-flops
	wire in_row = state_reg == ST_ROW;
	wire in_col = state_reg == ST_COL;
	wire in_pre = state_reg == ST_PRECHARGE;
	wire [1:0] ras_sel = in_row ? (2'h1 << cur_reg.bank) : 2'h0;
	wire [1:0] ras_low = ras_sel | (in_pre ? 2'h0 : open_valid);

	assign pins_next.addr = in_row ? cur_reg.addr : in_col ? col_addr : pins_reg.addr;
	assign pins_next.ras_n = ~ras_low;
	assign pins_next.cas_n = in_col ? ~lanes : 4'hf;

	// sequencer registers
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			state_reg <= ST_IDLE;
			cur_reg <= '0;
			cur_ctrl_reg <= `BANK_CTRL_RESET;
			beats_reg <= 3'h0;
			cnt_reg <= 4'h0;
			after_pre_reg <= 1'h0;
		end else if (clk_en) begin
			state_reg <= state_next;
			cur_reg <= cur_next;
			cur_ctrl_reg <= cur_ctrl_next;
			beats_reg <= beats_next;
			cnt_reg <= cnt_next;
			after_pre_reg <= after_pre_next;
		end
	end

	// output registers; strobes idle high out of reset
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			pins_reg <= {28'h0, 2'h3, 4'hf};
			done_reg <= 1'h0;
		end else if (clk_en) begin
			pins_reg <= pins_next;
			done_reg <= done_next;
		end
	end

	assign dram_pins = pins_reg;
	assign xfer_done = done_reg;
endmodule // dram_page_mode_address_mux

// file: core/dram_mux_cfg.svh
`ifndef DRAM_MUX_CFG_SVH
`define DRAM_MUX_CFG_SVH

// register byte offsets on the avalon slave
`define REG_BANK0_CTRL 4'h0
`define REG_BANK1_CTRL 4'h4
`define REG_STROBE_TIMING 4'h8
`define REG_STATUS 4'hc

// bank control field positions (lsb of each field)
`define CTRL_MODE_LSB 0
`define CTRL_WIDTH_LSB 2
`define CTRL_PAGE_LSB 4
`define CTRL_EXT_MUX_BIT 6

// page mode codes
`define MODE_NORMAL 2'h0
`define MODE_FAST 2'h1
`define MODE_BURST 2'h2

// port width codes
`define WIDTH_32 2'h0
`define WIDTH_8 2'h1
`define WIDTH_16 2'h2

// bank page size codes
`define PAGE_512 2'h0
`define PAGE_1K 2'h1
`define PAGE_2K 2'h2

// strobe timing field positions, each field is a count of extra cycles
`define TIM_RAS_TO_CAS_LSB 0
`define TIM_CAS_WIDTH_LSB 4
`define TIM_PRECHARGE_LSB 8

// status field positions
`define STAT_BUSY_BIT 0
`define STAT_OPEN_LSB 1
`define STAT_BEATS_LSB 3

// reset values
`define BANK_CTRL_RESET 7'h00
`define STROBE_TIMING_RESET 12'h000

// first column pin for a 512 byte page, and top column pin for that page on an 8-bit port
`define COL_BASE_PIN 5'h09
`define COL_TOP_PIN 5'h11

`endif

// file: core/dram_mux_pkg.sv
`include "dram_mux_cfg.svh"

package dram_mux_pkg;

	// per bank control word
	typedef struct packed {
		logic ext_mux;
		logic [1:0] page_size;
		logic [1:0] port_width;
		logic [1:0] page_mode;
	} bank_ctrl_t;

	// one timing set shared by both banks
	typedef struct packed {
		logic [3:0] precharge;
		logic [3:0] cas_width;
		logic [3:0] ras_to_cas;
	} strobe_timing_t;

	// transfer request: size 0 byte, 1 word, 2 long
	typedef struct packed {
		logic [27:0] addr;
		logic bank;
		logic [1:0] size;
		logic ext;
	} xfer_req_t;

	// dram facing pins
	typedef struct packed {
		logic [27:0] addr;
		logic [1:0] ras_n;
		logic [3:0] cas_n;
	} pin_out_t;

	// log2 of port width in bytes
	function automatic logic [1:0] port_shift(input logic [1:0] width);
		case (width)
			`WIDTH_8: port_shift = 2'h0;
			`WIDTH_16: port_shift = 2'h1;
			default: port_shift = 2'h2;
		endcase
	endfunction

endpackage

// file: core/col_addr_mux.sv
`include "dram_mux_cfg.svh"

module col_addr_mux (
	// address and bank geometry
	input wire logic [27:0] internal_transfer_address,
	input wire logic [1:0] bank_port_width,
	input wire logic [1:0] bank_page_size,
	input wire logic mux_on,
	// column phase pin values
	output logic [27:0] col_addr
);
	import dram_mux_pkg::*;

	// column field edges move with page size and port width
	wire [1:0] shift_w = port_shift(bank_port_width);
	wire [4:0] lo_pin = `COL_BASE_PIN + {3'h0, bank_page_size};
	wire [4:0] hi_pin = `COL_TOP_PIN + {2'h0, bank_page_size, 1'h0} - {3'h0, shift_w};

	// one selector per pin keeps the board wiring fixed across dram sizes
	genvar k;
	generate
		for (k = 0; k < 28; k++) begin : g_pin
			localparam logic [4:0] PIN = 5'(k);
			wire [4:0] idx;
			// pins under the field repeat the row, pins over it carry paired upper bits
			assign idx = (PIN < lo_pin) ? PIN :
				(PIN <= hi_pin) ? (PIN - lo_pin + {3'h0, shift_w}) :
				(PIN - {4'h0, PIN[0] ^ shift_w[0]});
			assign col_addr[k] = mux_on ? internal_transfer_address[idx] :
				internal_transfer_address[k];
		end
	endgenerate
endmodule // col_addr_mux

// file: core/page_tracker.sv
`include "dram_mux_cfg.svh"

module page_tracker (
	// clock and control
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic clk_en,
	// page lookup
	input wire logic [27:0] chk_addr,
	input wire logic chk_bank,
	input wire logic [1:0] chk_page_size,
	// update strobes
	input wire logic open_pulse,
	input wire logic close_pulse,
	// state
	output logic hit,
	output logic [1:0] open_valid
);
	// row of the open page per bank
	logic [27:0] open_row_reg [2];
	logic [1:0] valid_reg;
	wire [4:0] row_lsb = `COL_BASE_PIN + {3'h0, chk_page_size};
	wire [27:0] row_diff = (chk_addr ^ open_row_reg[chk_bank]) >> row_lsb;

	genvar b;
	generate
		for (b = 0; b < 2; b++) begin : g_bank
			// close wins: every miss precharges all banks
			always_ff @(posedge clk_sys) begin
				if (reset) begin
					valid_reg[b] <= 1'h0;
					open_row_reg[b] <= 28'h0;
				end else if (clk_en & close_pulse) begin
					valid_reg[b] <= 1'h0;
				end else if (clk_en & open_pulse & (chk_bank == 1'(b))) begin
					valid_reg[b] <= 1'h1;
					open_row_reg[b] <= chk_addr;
				end
			end
		end
	endgenerate

	assign hit = valid_reg[chk_bank] & (row_diff == 28'h0);
	assign open_valid = valid_reg;
endmodule // page_tracker

// file: tb/dram_mux_properties.sv
module dram_mux_properties (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic clk_en,
	// register bus
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	// transfers and pins
	input wire logic req_valid,
	input wire logic req_ready,
	input wire logic xfer_done,
	input wire dram_mux_pkg::pin_out_t dram_pins
);
	import dram_mux_pkg::*;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);
	// request taken, then answered in bounded time
	sequence s_take;
		req_valid && req_ready;
	endsequence
	sequence s_done;
		##[1:250] xfer_done;
	endsequence
	// row strobe has just been asserted
	sequence s_ras_fall;
		dram_pins.ras_n != 2'b11 && $past(dram_pins.ras_n) == 2'b11;
	endsequence
	wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest && clk_en
		|=> !avs_waitrequest) else $error("bus wait longer than one cycle");
	idle_wait_a: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
		else $error("wait asserted with no access");
	busy_after_a: assert property (s_take |=> !req_ready) else $error("ready after accept");
	take_done_a: assert property (s_take |-> s_done) else $error("transfer never done");
	ras_first_a: assert property (s_ras_fall |-> dram_pins.cas_n == 4'hf)
		else $error("column strobe with row strobe edge");
	cas_in_row_a: assert property (dram_pins.cas_n != 4'hf |-> dram_pins.ras_n != 2'b11)
		else $error("column strobe without row");
	one_bank_a: assert property (dram_pins.ras_n != 2'b00)
		else $error("two pages open");
	done_cas_a: assert property (xfer_done |-> dram_pins.cas_n != 4'hf)
		else $error("done outside column phase");
	row_hold_a: assert property (dram_pins.ras_n != 2'b11 && dram_pins.cas_n == 4'hf
		&& $past(dram_pins.cas_n) == 4'hf && $past(dram_pins.ras_n) != 2'b11
		|-> $stable(dram_pins.addr)) else $error("row address moved");
endmodule // dram_mux_properties

bind dram_page_mode_address_mux dram_mux_properties chk (.clk_sys(clk_sys), .reset(reset),
	.clk_en(clk_en), .avs_read(avs_read), .avs_write(avs_write),
	.avs_waitrequest(avs_waitrequest), .req_valid(req_valid), .req_ready(req_ready),
	.xfer_done(xfer_done), .dram_pins(dram_pins));

// file: tb/dram_chip_model.sv
module dram_chip_model (
	// controller clock
	input wire logic clk_sys,
	// controller pins
	input wire dram_mux_pkg::pin_out_t dram_pins
);
	timeunit 1ns;
	timeprecision 1ps;
	import dram_mux_pkg::*;
	// last pin state, strobes idle at start
	pin_out_t prev = '1;
	// strobe counts, times and latched values
	int cyc = 0;
	int row_cnt = 0;
	int col_cnt = 0;
	int t_ras = 0;
	int t_cas = 0;
	logic [27:0] row_a = '0;
	logic [27:0] col_a = '0;
	logic [1:0] ras_v = 2'h3;
	logic [3:0] cas_v = 4'hf; // lane strobes seen with the last column
	always @(posedge clk_sys) begin
		cyc++;
		// row strobe falls: latch row
		if (dram_pins.ras_n != 2'b11 && prev.ras_n == 2'b11) begin
			row_cnt++;
			row_a = dram_pins.addr;
			ras_v = dram_pins.ras_n;
			t_ras = cyc;
		end
		// a new column under the column strobe; bursts step the address
		if (dram_pins.cas_n != 4'hf && (prev.cas_n == 4'hf || dram_pins.addr != prev.addr)) begin
			col_cnt++;
			col_a = dram_pins.addr;
			cas_v = dram_pins.cas_n;
			t_cas = cyc;
		end
		prev = dram_pins;
	end
endmodule // dram_chip_model

// file: tb/tb_top.sv
`include "dram_mux_cfg.svh"

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import dram_mux_pkg::*;
	// design inputs
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic clk_en = 1'b1;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic req_valid = 1'b0;
	xfer_req_t req = '0;
	// design outputs
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic req_ready;
	logic xfer_done;
	pin_out_t dram_pins;
	// bench state
	int errors = 0;
	int compares = 0;
	int r0;
	int c0;
	logic [31:0] q;
	// geometry rows: width, page, address
	typedef struct {logic [1:0] w; logic [1:0] p; logic [27:0] a;} row_t;
	row_t rows [9];
	// register write/read-back table
	logic [3:0] ra [5] = '{4'h0, 4'h4, 4'h8, 4'hc, 4'h2};
	logic [31:0] rm [5] = '{32'h7f, 32'h7f, 32'hfff, 32'h0, 32'h0};
	// modes normal, burst, fast and rows expected for two longs in a page
	logic [1:0] md [3] = '{2'h0, 2'h2, 2'h1};
	int er [3] = '{2, 2, 1};

	always #2 clk_sys = ~clk_sys;

	dram_page_mode_address_mux uut (.clk_sys(clk_sys), .reset(reset), .clk_en(clk_en),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .req_valid(req_valid), .req_ready(req_ready),
		.req(req), .xfer_done(xfer_done), .dram_pins(dram_pins));
	dram_chip_model mdl (.clk_sys(clk_sys), .dram_pins(dram_pins));

	// column phase pins worked out per width and page
	function automatic logic [27:0] colmap(input logic [27:0] a, input logic [1:0] w,
		input logic [1:0] p);
		int sh;
		int top;
		sh = (w == `WIDTH_8) ? 0 : (w == `WIDTH_16) ? 1 : 2;
		top = 17 + 2 * p - sh;
		for (int k = 0; k < 28; k++) begin
			if (k < 9 + p) colmap[k] = a[k];
			else if (k <= top) colmap[k] = a[k - 9 - p + sh];
			else colmap[k] = a[k - ((k ^ sh) & 1)];
		end
	endfunction

	// active low lane strobes for one byte; narrow ports sit on the low lanes
	function automatic logic [3:0] lane_n(input logic [27:0] a, input logic [1:0] w);
		if (w == `WIDTH_8) lane_n = 4'he;
		else if (w == `WIDTH_16) lane_n = ~(4'h1 << a[0]);
		else lane_n = ~(4'h1 << a[1:0]);
	endfunction

	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			errors++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask

	task test_end(input string n);
		$display("test %s done", n);
	endtask

	// avalon access held until waitrequest is seen low
	task bus(input logic [3:0] a, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_sys);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		do begin
			@(posedge clk_sys);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		if (n >= 20) errors++;
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	// one transfer: wait for accept, then for done
	// hold above zero drops the clock enable for that many cycles just after accept
	task xfer(input logic [27:0] a, input logic b, input logic [1:0] s, input logic e,
		input int hold = 0);
		int n;
		int k;
		n = 0;
		@(posedge clk_sys);
		req_valid <= 1'b1;
		req <= '{addr: a, bank: b, size: s, ext: e};
		do begin
			@(posedge clk_sys);
			n++;
		end while (req_ready !== 1'b1 && n < 50);
		req_valid <= 1'b0;
		if (hold > 0) begin
			clk_en <= 1'b0;
			k = mdl.row_cnt;
			repeat (hold) @(posedge clk_sys);
			// no row strobe may fall and no done may appear while frozen
			chk("frozen rows", k, mdl.row_cnt);
			chk("frozen done", 32'h0, xfer_done);
			clk_en <= 1'b1;
		end
		do begin
			@(posedge clk_sys);
			n++;
		end while (xfer_done !== 1'b1 && n < 100);
		if (n >= 100) errors++;
		repeat (4) @(posedge clk_sys);
	endtask

	task close_out;
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	initial begin
		for (int i = 0; i < 9; i++) rows[i] = '{2'(i / 3), 2'(i % 3), 28'h9a5c3e7 + 28'(i) * 28'h1357};
		repeat (8) @(posedge clk_sys);
		reset <= 1'b0;
		// reset values, masks, read-only and unmapped places
		for (int i = 0; i < 5; i++) begin
			bus(ra[i], 1'b0, 32'h0);
			chk("reset value", 32'h0, q);
			bus(ra[i], 1'b1, 32'hffffffff);
			bus(ra[i], 1'b0, 32'h0);
			chk("read back", rm[i], q);
		end
		bus(4'h8, 1'b1, 32'h0);
		test_end("registers");
		// every width and page, core transfer in normal mode
		for (int i = 0; i < 9; i++) begin
			bus(4'h0, 1'b1, {26'h0, rows[i].p, rows[i].w, 2'h0});
			xfer(rows[i].a, 1'b0, 2'h0, 1'b0);
			chk("row phase", rows[i].a, mdl.row_a);
			q = {4'h0, colmap(rows[i].a, rows[i].w, rows[i].p)};
			chk("column phase", q, mdl.col_a);
			chk("lane strobes", lane_n(rows[i].a, rows[i].w), mdl.cas_v);
		end
		test_end("geometry");
		// two longs in one page for each mode
		for (int j = 0; j < 3; j++) begin
			bus(4'h0, 1'b1, {30'h0, md[j]});
			r0 = mdl.row_cnt;
			c0 = mdl.col_cnt;
			xfer(28'h0001000, 1'b0, 2'h2, 1'b0);
			xfer(28'h0001004, 1'b0, 2'h2, 1'b0);
			chk("row phases", er[j], mdl.row_cnt - r0);
			chk("column phases", 32'h2, mdl.col_cnt - c0);
		end
		test_end("page modes");
		// misses: other bank, then another row
		bus(4'h4, 1'b1, 32'h1);
		r0 = mdl.row_cnt;
		xfer(28'h0001008, 1'b1, 2'h2, 1'b0);
		chk("bank strobe", 32'h1, mdl.ras_v);
		xfer(28'h000100c, 1'b0, 2'h2, 1'b0);
		xfer(28'h0003000, 1'b0, 2'h2, 1'b0);
		chk("miss rows", 32'h3, mdl.row_cnt - r0);
		test_end("page miss");
		// long burst on an 8-bit port
		bus(4'h0, 1'b1, 32'h6);
		r0 = mdl.row_cnt;
		c0 = mdl.col_cnt;
		xfer(28'h0002000, 1'b0, 2'h2, 1'b0);
		chk("burst rows", 32'h1, mdl.row_cnt - r0);
		chk("burst beats", 32'h4, mdl.col_cnt - c0);
		test_end("burst");
		// external master with and without multiplexing
		bus(4'h0, 1'b1, 32'h4);
		xfer(28'h0f0f5a5, 1'b0, 2'h0, 1'b1);
		chk("ext column", 28'h0f0f5a5, mdl.col_a);
		bus(4'h0, 1'b1, 32'h44);
		xfer(28'h0f0f5a5, 1'b0, 2'h0, 1'b1);
		chk("ext mux column", colmap(28'h0f0f5a5, 2'h1, 2'h0), mdl.col_a);
		test_end("external");
		// one timing set serves both banks
		bus(4'h8, 1'b1, 32'h2);
		bus(4'h0, 1'b1, 32'h0);
		bus(4'h4, 1'b1, 32'h0);
		for (int b = 0; b < 2; b++) begin
			xfer(28'h0004000, b[0], 2'h0, 1'b0);
			chk("row to column", 32'h3, mdl.t_cas - mdl.t_ras);
		end
		test_end("timing");
		// clock enable low holds a transfer in flight, which then completes
		r0 = mdl.row_cnt;
		xfer(28'h0005000, 1'b0, 2'h0, 1'b0, 10);
		chk("rows after freeze", 32'h1, mdl.row_cnt - r0);
		test_end("freeze");
		// reset in mid-run drops an open page and clears the registers
		bus(4'h0, 1'b1, 32'h1);
		xfer(28'h0006000, 1'b0, 2'h0, 1'b0);
		chk("open page strobe", 32'h2, dram_pins.ras_n);
		reset <= 1'b1;
		repeat (3) @(posedge clk_sys);
		chk("strobes in reset", 32'h3f, {dram_pins.ras_n, dram_pins.cas_n});
		reset <= 1'b0;
		bus(4'h8, 1'b0, 32'h0);
		chk("timing after reset", 32'h0, q);
		bus(4'h0, 1'b0, 32'h0);
		chk("control after reset", 32'h0, q);
		test_end("reset");
		close_out;
	end

	// watchdog
	initial begin
		#150000;
		errors++;
		close_out;
	end
endmodule // tb_top
